// ---- rtl/drm_rate_mult.sv ----
// Purpose: Synchronous decade rate multiplier with Avalon-MM control.
// Assumes: All pins synchronous to clk (40 MHz); ce freezes every flop.
// Notes: Z, Y and the enable output are registered, one cycle after the
//        counter step that produced them.
`timescale 1ns/1ps
module drm_rate_mult
    import drm_pkg::*;
#(
    parameter int TALLY_W = 16
)
(
    // Clock, reset, clock enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    // Counter control pins
    input wire logic clear,
    input wire logic enable_n,
    input wire logic strobe,
    input wire logic set_nine,
    input wire logic unity_cascade,
    // Rate pins
    input wire logic rate_weight_one,
    input wire logic rate_weight_two,
    input wire logic rate_weight_four,
    input wire logic rate_weight_eight,
    // Outputs
    output logic z_out,
    output logic y_out,
    output logic enable_out_n,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);

    // Software control and rate registers
    logic [DRM_CTRL_W-1:0] ctrl_reg;
    logic [3:0] rate_sw_reg;
    // Pulse tally readable by software
    logic [TALLY_W-1:0] tally_reg;
    // Decade counter
    drm_count_e count_reg;
    drm_count_e count_next;
    // Registered outputs
    logic z_reg;
    logic y_reg;
    logic en_out_reg;
    // Bus answer phase
    logic ack_reg;
    logic [31:0] rdata_reg;

    // Effective controls, pin ORed with software bit
    logic clear_eff;
    logic strobe_eff;
    logic nine_eff;
    logic hold_eff;
    logic [3:0] rate_pins; // Rate as seen on the pins
    logic [3:0] rate_code; // Rate actually decoded
    logic adv; // Counter steps this cycle
    logic hit; // Decode gates fire for this state
    logic z_next;
    logic wr_take; // Write takes effect this edge
    logic rd_take; // Read data latched this edge
    logic tally_clr; // Software clears the tally

    // Pins combine with software so either may inhibit the counter
    assign clear_eff = clear | ctrl_reg[DRM_CTRL_CLEAR];
    assign strobe_eff = strobe | ctrl_reg[DRM_CTRL_STROBE];
    assign nine_eff = set_nine | ctrl_reg[DRM_CTRL_NINE];
    assign hold_eff = enable_n | ctrl_reg[DRM_CTRL_HOLD];

    // Weighted code, eight four two one
    assign rate_pins = {rate_weight_eight, rate_weight_four,
        rate_weight_two, rate_weight_one};
    // Read live every cycle, so variable rates are followed at once
    assign rate_code = ctrl_reg[DRM_CTRL_RATE_SEL] ? rate_sw_reg : rate_pins;

    // Counting needs all four controls low
    assign adv = ce & ~clear_eff & ~strobe_eff & ~nine_eff & ~hold_eff;

    // Rate decoding gates
    drm_rate_decode u_decode (
        .count(count_reg),
        .rate(rate_code),
        .hit(hit)
    );

    // Z low for one clock per decoded state; strobe blocks the gates
    assign z_next = ~(adv & ~strobe_eff & hit);

    // Next counter state; clear beats set-to-nine beats counting
    always_comb begin
        count_next = count_reg;
        if (clear_eff) begin
            count_next = DRM_S0;
        end else if (nine_eff) begin
            count_next = DRM_S9;
        end else if (adv) begin
            case (count_reg)
                DRM_S0: count_next = DRM_S1;
                DRM_S1: count_next = DRM_S2;
                DRM_S2: count_next = DRM_S3;
                DRM_S3: count_next = DRM_S4;
                DRM_S4: count_next = DRM_S5;
                DRM_S5: count_next = DRM_S6;
                DRM_S6: count_next = DRM_S7;
                DRM_S7: count_next = DRM_S8;
                DRM_S8: count_next = DRM_S9;
                DRM_S9: count_next = DRM_S0;
                // Illegal codes fall back to zero
                default: count_next = DRM_S0;
            endcase
        end
    end

    // Decade counter register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_reg <= DRM_S0;
        end else if (ce) begin
            count_reg <= count_next;
        end
    end

    // Z output, high when idle or rate zero
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            z_reg <= 1'b1;
        end else if (ce) begin
            z_reg <= z_next;
        end
    end

    // Y is NAND of Z and unity: low unity inhibits Y, else Y is not-Z;
    // with the strobe high Z stays high so Y follows unity inverted.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            y_reg <= 1'b1;
        end else if (ce) begin
            y_reg <= ~(z_next & unity_cascade);
        end
    end

    // Enable output goes low for the step that closes a decade,
    // so a chained stage steps once per ten of ours.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            en_out_reg <= 1'b1;
        end else if (ce) begin
            en_out_reg <= ~(adv & (count_reg == DRM_S9));
        end
    end

    assign z_out = z_reg;
    assign y_out = y_reg;
    assign enable_out_n = en_out_reg;

    // Bus handshake: first edge latches read data, second edge completes
    // Trade-off: one wait state for every access keeps decode off the
    // readdata path.
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign wr_take = ce & avs_write & ack_reg;
    assign rd_take = ce & avs_read & ~ack_reg;
    assign tally_clr = wr_take & (avs_address == DRM_ADDR_TALLY) & avs_byteenable[0];

    // Answer phase flag
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_reg <= 1'b0;
        end else if (ce) begin
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
        end
    end

    // Control register, low byte only
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_reg <= DRM_CTRL_RESET;
        end else if (wr_take && avs_address == DRM_ADDR_CTRL && avs_byteenable[0]) begin
            ctrl_reg <= avs_writedata[DRM_CTRL_W-1:0];
        end
    end

    // Software rate value
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rate_sw_reg <= DRM_RATE_RESET;
        end else if (wr_take && avs_address == DRM_ADDR_RATE && avs_byteenable[0]) begin
            rate_sw_reg <= avs_writedata[3:0];
        end
    end

    // Pulse tally; a pulse in the clearing cycle is kept
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tally_reg <= '0;
        end else if (ce) begin
            if (!z_next) begin
                if (tally_clr) begin
                    tally_reg <= TALLY_W'(1);
                end else begin
                    tally_reg <= tally_reg + TALLY_W'(1);
                end
            end else if (tally_clr) begin
                tally_reg <= '0;
            end
        end
    end

    // Read data mux; unmapped addresses read zero
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_reg <= 32'h0000_0000;
        end else if (rd_take) begin
            case (avs_address)
                DRM_ADDR_CTRL: begin
                    rdata_reg <= {{(32-DRM_CTRL_W){1'b0}}, ctrl_reg};
                end
                DRM_ADDR_RATE: begin
                    rdata_reg <= {28'h0000000, rate_sw_reg};
                end
                DRM_ADDR_STATUS: begin
                    rdata_reg <= {24'h000000, adv, en_out_reg, y_reg, z_reg, count_reg};
                end
                DRM_ADDR_TALLY: begin
                    rdata_reg <= 32'(tally_reg);
                end
                default: begin
                    rdata_reg <= 32'h0000_0000;
                end
            endcase
        end
    end

    assign avs_readdata = rdata_reg;

    // Checks on the counter and outputs
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // Last step of a decade and the wrap that follows it
    sequence s_last_step;
        adv && count_reg == DRM_S9;
    endsequence
    sequence s_wrapped;
        count_reg == DRM_S0 && !en_out_reg;
    endsequence

    // Clear or set-to-nine applied, then its held state
    sequence s_clear_cmd;
        ce && clear_eff;
    endsequence
    sequence s_nine_cmd;
        ce && nine_eff && !clear_eff;
    endsequence

    // Counting step whose state the gates decode
    sequence s_pulse;
        adv && hit;
    endsequence

    count_hold_a: assert property (
        ce && !adv && !clear_eff && !nine_eff |=> $stable(count_reg))
        else $error("counter moved while not enabled");

    decade_wrap_a: assert property (
        s_last_step |=> s_wrapped ##1 (en_out_reg || !$past(ce)))
        else $error("decade wrap or enable output wrong");

    mid_decade_a: assert property (
        ce && count_reg != DRM_S9 |=> en_out_reg)
        else $error("enable output low mid decade");

    zero_rate_a: assert property (
        ce && rate_code == 4'h0 |=> z_reg)
        else $error("Z pulsed at rate zero");

    strobe_block_a: assert property (
        ce && strobe_eff |=> z_reg && count_reg == $past(count_next))
        else $error("Z pulsed while strobed");

    rate_pulse_a: assert property (
        s_pulse |=> !z_reg)
        else $error("decoded state gave no Z pulse");

    // A pulse lasts one clock unless the next step is decoded too
    z_idle_a: assert property (
        ce && !(adv && hit) |=> z_reg)
        else $error("Z low without a decoded step");

    clear_zero_a: assert property (
        s_clear_cmd |=> count_reg == DRM_S0 && z_reg && en_out_reg)
        else $error("clear did not hold zero");

    set_nine_a: assert property (
        s_nine_cmd |=> count_reg == DRM_S9)
        else $error("set-to-nine did not preset");

    over_range_a: assert property (
        adv && rate_code[3] && rate_code[0] && count_reg != DRM_S4 |=> !z_reg)
        else $error("over-range code missed a pulse");

    rate_follow_a: assert property (
        adv && $changed(rate_code) && hit |=> !z_reg)
        else $error("new rate not followed at once");

    y_inhibit_a: assert property (
        ce && !unity_cascade |=> y_reg)
        else $error("Y not inhibited by low unity");

    y_pass_a: assert property (
        ce && strobe_eff |=> y_reg == !$past(unity_cascade))
        else $error("Y did not pass inverted unity");

    y_complement_a: assert property (
        ce && unity_cascade |=> y_reg == !z_reg)
        else $error("Y not complement of Z");

    // Decade mark is a single clock and only right after the wrap
    en_pulse_a: assert property (
        ce && !en_out_reg |=> en_out_reg)
        else $error("enable output low for two clocks");

    mark_state_a: assert property (
        !en_out_reg |-> count_reg == DRM_S0)
        else $error("enable output low away from state zero");

    // Strobe stops the counter, so no decade mark can follow
    strobe_mark_a: assert property (
        ce && strobe_eff |=> en_out_reg)
        else $error("decade mark while strobed");

    // Only weight one owns state nine; even codes skip it
    decode_nine_a: assert property (
        adv && rate_code[3] && !rate_code[0] && count_reg == DRM_S9 |=> z_reg)
        else $error("even over-range code pulsed in state nine");

    y_clear_a: assert property (
        ce && clear_eff && strobe_eff && unity_cascade |=> !y_reg && z_reg && en_out_reg)
        else $error("clear levels of Y, Z or mark wrong");

    // Low clock enable freezes counter and every output flop
    ce_freeze_a: assert property (
        !ce |=> $stable(count_reg) && $stable(z_reg) && $stable(y_reg)
            && $stable(en_out_reg))
        else $error("state moved with clock enable low");

endmodule

// ---- common/drm_pkg.sv ----
// Purpose: Shared constants and types for the decade rate multiplier.
// Assumes: Avalon-MM byte addresses, 32-bit data, one word per register.
// Notes: Summary of operation follows.
// Summary of operation
// - Counter advances only when clear, strobe, nine, enable low.
// - M output pulses per ten enabled clocks.
// - Rate M weighted eight, four, two, one.
// - Rate zero keeps Z high, no pulses.
// - Strobed-off decode passes inverted unity input to Y.
// - Strobe high blocks rate pulses; low passes them.
// - Clear holds zero; Y low, Z, enable high. Here Y is low only while unity is high.
// - Codes above nine give eight or nine pulses.
// - Rate may change while running; current value used.
// - Unity low forces Y high; else Y is not-Z.
package drm_pkg;

    // Register byte offsets
    localparam logic [3:0] DRM_ADDR_CTRL = 4'h0;
    localparam logic [3:0] DRM_ADDR_RATE = 4'h4;
    localparam logic [3:0] DRM_ADDR_STATUS = 4'h8;
    localparam logic [3:0] DRM_ADDR_TALLY = 4'hc;

    // Control register field positions
    localparam int DRM_CTRL_CLEAR = 0;
    localparam int DRM_CTRL_STROBE = 1;
    localparam int DRM_CTRL_NINE = 2;
    localparam int DRM_CTRL_HOLD = 3;
    localparam int DRM_CTRL_RATE_SEL = 4;
    localparam int DRM_CTRL_W = 5;

    // Status register field positions
    localparam int DRM_STAT_Z = 4;
    localparam int DRM_STAT_Y = 5;
    localparam int DRM_STAT_EN = 6;
    localparam int DRM_STAT_ADV = 7;

    // Values after reset
    localparam logic [4:0] DRM_CTRL_RESET = 5'h00;
    localparam logic [3:0] DRM_RATE_RESET = 4'h0;

    // Decade counter states, binary coded
    typedef enum logic [3:0] {
        DRM_S0 = 4'h0,
        DRM_S1 = 4'h1,
        DRM_S2 = 4'h2,
        DRM_S3 = 4'h3,
        DRM_S4 = 4'h4,
        DRM_S5 = 4'h5,
        DRM_S6 = 4'h6,
        DRM_S7 = 4'h7,
        DRM_S8 = 4'h8,
        DRM_S9 = 4'h9
    } drm_count_e;

endpackage

// ---- rtl/drm_rate_decode.sv ----
// Purpose: Rate decoding gates of the decade rate multiplier.
// Assumes: Counter state 0 to 9; rate code taken straight from its source.
// Notes: Combinational; weight sets chosen so pulses spread over the decade.
`timescale 1ns/1ps
module drm_rate_decode
    import drm_pkg::*;
(
    // Counter state
    input wire logic [3:0] count,
    // Weighted rate code
    input wire logic [3:0] rate,
    // Decode result
    output logic hit
);

    // Membership of the current state in each weight set
    logic in_eight; // Every state but 4 and 9
    logic in_four; // States 0, 2, 5, 7
    logic in_two; // States 1, 6
    logic in_one; // State 9 only

    // Four and two sets sit inside the eight set, so codes above nine
    // collapse to eight or nine pulses, depending only on the low bit.
    always_comb begin
        in_eight = (count != 4'h4) && (count <= 4'h8);
        in_four = 1'b0;
        in_two = 1'b0;
        in_one = 1'b0;
        case (count)
            4'h0, 4'h2, 4'h5, 4'h7: begin
                in_four = 1'b1;
            end
            4'h1, 4'h6: begin
                in_two = 1'b1;
            end
            4'h9: begin
                in_one = 1'b1;
            end
            default: begin
                in_four = 1'b0;
            end
        endcase
    end

    // AND-OR of weights against state sets
    assign hit = (rate[3] & in_eight) | (rate[2] & in_four) | (rate[1] & in_two)
        | (rate[0] & in_one);

endmodule

// ---- bench/drm_cascade_partner.sv ----
// Purpose: Far-side model feeding the unity/cascade pin.
// Assumes: Mode is set by the bench; changes land on rising edges.
// Notes: Mode 0 acts as a chained stage at rate zero, 1 as a clock
//        source, 2 as a stage that inhibits Y.
`timescale 1ns/1ps
module drm_cascade_partner (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Behaviour select
    input wire logic [1:0] mode,
    // Level fed to the unity/cascade pin
    output logic unity
);
    // Other stage's Z, or a clock image; one flop keeps it edge aligned
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            unity <= 1'b1; // Idle stage: its Z rests high
        end else if (mode == 2'h1) begin
            unity <= ~unity; // Clock source, half rate of clk
        end else begin
            unity <= (mode == 2'h0); // Chained Z level
        end
    end
endmodule

// ---- bench/tb_decade_rate_multiplier.sv ----
// Purpose: Self-checking bench for the decade rate multiplier.
// Assumes: One bus wait state or more; pins sampled at rising edges.
// Notes: Pulses are counted over windows of ten cycles.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin err_total++; \
    $display("[ERR] %s expected %0h seen %0h", nm, ex, gt); end end
module tb_decade_rate_multiplier;
    import drm_pkg::*;
    // Clock, reset and pins
    logic clk, sys_rst, clear, enable_n, strobe, set_nine, z_out, y_out, enable_out_n, uc;
    logic ce; // Clock enable into the block
    logic [3:0] rate_code; // Rate pins, weight eight down to one
    logic [1:0] pmode; // Partner behaviour
    // Bus
    logic [3:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata, rd;
    int err_total, num_checks;

    drm_rate_mult i_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .clear(clear),
        .enable_n(enable_n), .strobe(strobe), .set_nine(set_nine), .unity_cascade(uc),
        .rate_weight_one(rate_code[0]), .rate_weight_two(rate_code[1]),
        .rate_weight_four(rate_code[2]), .rate_weight_eight(rate_code[3]),
        .z_out(z_out), .y_out(y_out), .enable_out_n(enable_out_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    drm_cascade_partner i_far (.clk(clk), .sys_rst(sys_rst), .mode(pmode), .unity(uc));

    // One Avalon access; request held until waitrequest is seen low
    task automatic bus(input logic [3:0] a, input logic wr, input logic [31:0] wd);
        int n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= wd;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        `CHK("bus wait state", 1'b1, n > 1)
    endtask

    // Pin levels change together just after an edge
    task automatic pins(input logic c, en, s, n9, input logic [3:0] r);
        @(posedge clk);
        clear <= c;
        enable_n <= en;
        strobe <= s;
        set_nine <= n9;
        rate_code <= r;
    endtask

    // Every code, changed while running; pulses per decade and Y gating
    task automatic t_rates(input logic [1:0] m);
        int zc, ec, exp;
        pmode <= m;
        for (int c = 0; c < 16; c++) begin
            pins(1'b0, 1'b0, 1'b0, 1'b0, c[3:0]);
            repeat (2) @(posedge clk);
            zc = 0;
            ec = 0;
            exp = (c < 10) ? c : (c[0] ? 9 : 8);
            repeat (10) begin
                @(posedge clk);
                zc += (z_out === 1'b0);
                ec += (enable_out_n === 1'b0);
                if (m == 2'h0) `CHK("y not z", ~z_out, y_out)
                else `CHK("y inhibited", 1'b1, y_out)
            end
            `CHK("z pulses", exp, zc)
            `CHK("decade marks", 1, ec)
        end
        $display("test rates mode %0d done", m);
    endtask

    // Strobe or hold: no pulses, count frozen, Y passes inverted unity
    task automatic t_freeze(input logic en, s);
        logic [31:0] s0;
        logic pu;
        pmode <= 2'h1;
        pins(1'b0, en, s, 1'b0, 4'h9);
        bus(DRM_ADDR_STATUS, 1'b0, '0);
        s0 = rd;
        @(posedge clk);
        pu = uc;
        repeat (10) begin
            @(posedge clk);
            `CHK("z blocked", 1'b1, z_out)
            `CHK("y clock image", ~pu, y_out)
            pu = uc;
        end
        bus(DRM_ADDR_STATUS, 1'b0, '0);
        `CHK("count frozen", s0[3:0], rd[3:0])
        $display("test freeze %0b%0b done", en, s);
    endtask

    // Preset to nine, then the step to zero gives Z and decade mark
    task automatic t_nine();
        pmode <= 2'h0;
        pins(1'b0, 1'b0, 1'b0, 1'b1, 4'h1);
        repeat (2) @(posedge clk);
        bus(DRM_ADDR_STATUS, 1'b0, '0);
        `CHK("nine preset", 4'h9, rd[3:0])
        pins(1'b0, 1'b0, 1'b0, 1'b0, 4'h1);
        repeat (2) @(posedge clk);
        `CHK("z at wrap", 1'b0, z_out)
        `CHK("mark at wrap", 1'b0, enable_out_n)
        $display("test nine done");
    endtask

    // Clear by pin and by register; map and unmapped read
    task automatic t_clear();
        pins(1'b1, 1'b0, 1'b1, 1'b0, 4'h9);
        repeat (3) @(posedge clk);
        `CHK("clear z", 1'b1, z_out)
        `CHK("clear y", 1'b0, y_out)
        `CHK("clear mark", 1'b1, enable_out_n)
        bus(DRM_ADDR_STATUS, 1'b0, '0);
        `CHK("clear count", 4'h0, rd[3:0])
        pins(1'b0, 1'b0, 1'b0, 1'b0, 4'h9);
        repeat (4) @(posedge clk);
        bus(DRM_ADDR_CTRL, 1'b1, 32'h1);
        bus(DRM_ADDR_STATUS, 1'b0, '0);
        `CHK("reg clear count", 4'h0, rd[3:0])
        bus(DRM_ADDR_CTRL, 1'b0, '0);
        `CHK("ctrl readback", 5'h01, rd[4:0])
        bus(DRM_ADDR_CTRL, 1'b1, 32'h0);
        bus(DRM_ADDR_RATE, 1'b0, '0);
        `CHK("rate reset", DRM_RATE_RESET, rd[3:0])
        bus(DRM_ADDR_RATE, 1'b1, 32'h3);
        bus(DRM_ADDR_RATE, 1'b0, '0);
        `CHK("rate readback", 4'h3, rd[3:0])
        bus(4'h2, 1'b0, '0);
        `CHK("unmapped read", 32'h0, rd)
        $display("test clear done");
    endtask

    // Software rate over exactly ten steps, tally, status flags, clock enable
    task automatic t_soft();
        logic [31:0] s0;
        pins(1'b0, 1'b1, 1'b0, 1'b0, 4'h0);
        bus(DRM_ADDR_RATE, 1'b1, 32'h5);
        bus(DRM_ADDR_CTRL, 1'b1, 32'h10);
        bus(DRM_ADDR_TALLY, 1'b1, 32'h0);
        pins(1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
        repeat (9) @(posedge clk);
        pins(1'b0, 1'b1, 1'b0, 1'b0, 4'h0);
        bus(DRM_ADDR_TALLY, 1'b0, '0);
        `CHK("tally", 32'h5, rd)
        bus(DRM_ADDR_STATUS, 1'b0, '0);
        `CHK("status flags", 4'h5, rd[7:4])
        s0 = rd;
        ce <= 1'b0;
        pins(1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
        repeat (5) @(posedge clk);
        pins(1'b0, 1'b1, 1'b0, 1'b0, 4'h0);
        ce <= 1'b1;
        bus(DRM_ADDR_STATUS, 1'b0, '0);
        `CHK("ce freeze", s0[3:0], rd[3:0])
        bus(DRM_ADDR_CTRL, 1'b1, 32'h0);
        $display("test soft done");
    endtask

    // Verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Watchdog, far beyond the fewer than six hundred cycles the tests need
    initial begin
        #500000;
        err_total++;
        close_out();
    end

    // Main sequence
    initial begin
        err_total = 0;
        num_checks = 0;
        sys_rst = 1'b1;
        ce = 1'b1;
        {clear, enable_n, strobe, set_nine} = 4'h0;
        rate_code = 4'h0;
        pmode = 2'h0;
        {avs_read, avs_write} = 2'h0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        t_rates(2'h0);
        t_rates(2'h2);
        t_freeze(1'b0, 1'b1);
        t_freeze(1'b1, 1'b0);
        t_nine();
        t_clear();
        t_soft();
        close_out();
    end
endmodule
